// ### logic/tsc_params.svh
// Purpose: constants of the tuner synthesizer serial control front end
// Assumes: included by every design file that needs them
// Notes: control byte layout is shared by the two-wire and three-wire paths
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

// ************************************************************
// two-wire link
// ************************************************************
`define TSC_I2C_ADDR 7'h61
`define TSC_BYTE_BITS 4'd8
`define TSC_MAX_BYTES 3'd4

// band-switch byte bit positions
`define TSC_BAND_UHF 2
`define TSC_BAND_TRAP 3
`define TSC_BAND_VHF_HI 1
`define TSC_BAND_VHF_LO 0

// ************************************************************
// three-wire link
// ************************************************************
`define TSC_TW_WIDTH 27
`define TSC_CNT_WIDTH 8
`define TSC_LEN_SHORT 8'd18
`define TSC_LEN_MID 8'd19
`define TSC_LEN_LONG 8'd27

// ************************************************************
// reset values
// ************************************************************
`define TSC_CTRL_RST 7'h42
`define TSC_PORTS_RST 4'h0
`define TSC_DIV_RST 15'h0000

`endif

// ### logic/tsc_pkg.sv
// Purpose: types of the tuner synthesizer serial control front end
// Assumes: nothing
// Notes: constants live in tsc_params.svh
`default_nettype none
package tsc_pkg;

	// reference divider choice
	typedef enum logic [1:0] {
		TSC_REF_64 = 2'b00,
		TSC_REF_80 = 2'b01,
		TSC_REF_128 = 2'b10
	} tsc_ref_t;

	// band-switch outputs
	typedef struct packed {
		logic uhf_band_port;
		logic sound_trap_port;
		logic vhf_high_port;
		logic vhf_low_port;
	} tsc_ports_t;

	// control settings, bit order matches the serial control byte [6:0]
	typedef struct packed {
		logic pump_current_select;
		logic test_mode_bit_high;
		logic test_mode_bit_mid;
		logic test_mode_bit_low;
		logic ref_ratio_select_a;
		logic ref_ratio_select_b;
		logic tuning_output_disable;
	} tsc_ctrl_t;

	// two-wire slave states
	typedef enum logic [2:0] {
		TSC_ST_IDLE = 3'b000,
		TSC_ST_ADDR = 3'b001,
		TSC_ST_AACK = 3'b010,
		TSC_ST_WR = 3'b011,
		TSC_ST_WACK = 3'b100,
		TSC_ST_RD = 3'b101,
		TSC_ST_RACK = 3'b110
	} tsc_st_t;

	// meaning of a written data byte
	typedef enum logic [2:0] {
		TSC_ROLE_DIV_HI = 3'b000,
		TSC_ROLE_DIV_LO = 3'b001,
		TSC_ROLE_CTRL = 3'b010,
		TSC_ROLE_BAND = 3'b011,
		TSC_ROLE_NONE = 3'b100
	} tsc_role_t;

endpackage
`default_nettype wire

// ### logic/tsc_link_rx.sv
// Purpose: three-wire receiver running on the link clock
// Assumes: data and enable meet set-up to the link clock edge
// Notes: the bit counter clears only at reset; the system side takes differences
`timescale 1ns/10ps
`default_nettype none
`include "tsc_params.svh"
module tsc_link_rx #(
	parameter int W = `TSC_TW_WIDTH,
	parameter int CW = `TSC_CNT_WIDTH
) (
	input wire logic link_clk, // three-wire clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic tw_en, // frame enable
	input wire logic tw_data, // serial data
	output logic [W-1:0] word_q, // last W bits shifted in
	output logic [CW-1:0] cnt_gray_q // gray-coded bit count
);

	logic [CW-1:0] cnt_bin_q;
	logic [CW-1:0] cnt_next;

	assign cnt_next = cnt_bin_q + 1'b1;

	// shift msb first; gray code lets the other domain read the count safely
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= '0;
			cnt_bin_q <= '0;
			cnt_gray_q <= '0;
		end else if (tw_en) begin
			word_q <= {word_q[W-2:0], tw_data};
			cnt_bin_q <= cnt_next;
			cnt_gray_q <= cnt_next ^ (cnt_next >> 1);
		end
	end

endmodule
`default_nettype wire

// ### logic/tsc_top.sv
// Purpose: serial control front end of a tuner frequency synthesizer
// Assumes: two-wire pins and status are asynchronous; link clock idles between frames
// Notes: both links are live at once; a three-wire commit wins a same-cycle clash
// How it works
// - first data bit zero: two divider bytes, then control and band bytes
// - first data bit one: control, band, then optional divider bytes
// - stop after divider bytes updates divider only
// - control plus band bytes keep the old divider
// - a lone control byte is applied by itself
// - read drives status bytes until master withholds acknowledge
// - after acknowledge, status is sampled afresh and sent on next eight clocks
// - 18-bit frame: four port bits then divider bits 13..0
// - 18-bit frame selects reference ratio 64 while select B is one
// - 19-bit frame: four port bits then divider bits 14..0
// - 19-bit frame selects reference ratio 128 while select B is one
// - select B cleared earlier keeps ratio 80 for short frames
// - 27-bit frame: ports, fifteen divider bits, eight control bits
// - both selects zero gives ratio 80; pump bit zero gives low current
// - control loaded by long frame persists through short frames
`timescale 1ns/10ps
`default_nettype none
`include "tsc_params.svh"
module tsc_top
	import tsc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `TSC_I2C_ADDR
) (
	input wire logic SYS_CLK, // system clock, 100 MHz
	input wire logic RST_N, // asynchronous reset, active low
	input wire logic SCL_IN, // two-wire clock pin
	input wire logic SDA_IN, // two-wire data pin level
	output logic SDA_OUT, // two-wire data drive value, always low
	output logic SDA_OE_N, // low while pulling data low
	input wire logic [7:0] STATUS_IN, // status byte from the synthesizer
	input wire logic TW_CLK, // three-wire clock, own domain
	input wire logic TW_EN, // three-wire enable
	input wire logic TW_DATA, // three-wire data
	output tsc_ports_t PORTS, // band-switch outputs
	output logic [14:0] DIVIDER_RATIO, // programmable divider ratio
	output tsc_ctrl_t CTRL, // control settings
	output tsc_ref_t REF_RATIO // reference divider ratio
);

	// ************************************************************
	// decoding helpers
	// ************************************************************

	// reference ratio from the two select bits
	function automatic tsc_ref_t ref_sel(input logic sel_a, input logic sel_b);
		tsc_ref_t r;
		r = TSC_REF_80;
		if (sel_b) begin
			r = sel_a ? TSC_REF_128 : TSC_REF_64;
		end
		return r;
	endfunction

	// role of a written byte from its position and the order flag
	function automatic tsc_role_t byte_role(input logic ctrl_first, input logic [2:0] idx);
		logic [1:0] pos;
		tsc_role_t r;
		pos = idx[1:0] ^ {ctrl_first, 1'b0};
		r = TSC_ROLE_NONE;
		if (idx < `TSC_MAX_BYTES) begin
			r = tsc_role_t'({1'b0, pos});
		end
		return r;
	endfunction

	// band-switch byte to port outputs
	function automatic tsc_ports_t band_of(input logic [7:0] b);
		tsc_ports_t p;
		p.uhf_band_port = b[`TSC_BAND_UHF];
		p.sound_trap_port = b[`TSC_BAND_TRAP];
		p.vhf_high_port = b[`TSC_BAND_VHF_HI];
		p.vhf_low_port = b[`TSC_BAND_VHF_LO];
		return p;
	endfunction

	// gray to binary for the link bit count
	function automatic logic [`TSC_CNT_WIDTH-1:0] gray2bin(input logic [`TSC_CNT_WIDTH-1:0] g);
		logic [`TSC_CNT_WIDTH-1:0] b;
		b = g;
		for (int i = `TSC_CNT_WIDTH - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [1:0] scl_sync_q, sda_sync_q, en_sync_q;
	logic scl_prev_q, sda_prev_q, en_prev_q;
	logic [7:0] stat_s1_q, stat_s2_q;
	logic [`TSC_TW_WIDTH-1:0] word_s1_q, word_s2_q;
	logic [`TSC_CNT_WIDTH-1:0] gray_s1_q, gray_s2_q;
	logic [`TSC_TW_WIDTH-1:0] link_word;
	logic [`TSC_CNT_WIDTH-1:0] link_gray;

	// only stage two is read; word and count are quiet whenever enable moves
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			en_sync_q <= 2'h0;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
			en_prev_q <= 1'b0;
			stat_s1_q <= 8'h00;
			stat_s2_q <= 8'h00;
			word_s1_q <= '0;
			word_s2_q <= '0;
			gray_s1_q <= '0;
			gray_s2_q <= '0;
		end else begin
			scl_sync_q <= {scl_sync_q[0], SCL_IN};
			sda_sync_q <= {sda_sync_q[0], SDA_IN};
			en_sync_q <= {en_sync_q[0], TW_EN};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
			en_prev_q <= en_sync_q[1];
			stat_s1_q <= STATUS_IN;
			stat_s2_q <= stat_s1_q;
			word_s1_q <= link_word;
			word_s2_q <= word_s1_q;
			gray_s1_q <= link_gray;
			gray_s2_q <= gray_s1_q;
		end
	end

	logic scl_rise, scl_fall, start_ev, stop_ev, sda_s;
	assign sda_s = sda_sync_q[1];
	assign scl_rise = scl_sync_q[1] & ~scl_prev_q;
	assign scl_fall = ~scl_sync_q[1] & scl_prev_q;
	assign start_ev = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_ev = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_s;

	// ************************************************************
	// two-wire slave
	// ************************************************************
	tsc_st_t st_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] sh_q;
	logic [2:0] byte_idx_q;
	logic order_q, rw_q, oe_n_q, sda_out_q;
	logic wr_done, ord_eff;
	tsc_role_t role;

	assign wr_done = (st_q == TSC_ST_WR) & scl_fall & (bit_cnt_q == `TSC_BYTE_BITS) & ~start_ev & ~stop_ev;
	assign ord_eff = (byte_idx_q == 3'h0) ? sh_q[7] : order_q;
	assign role = byte_role(ord_eff, byte_idx_q);

	// start and stop override any state; data moves on clock edges only
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= TSC_ST_IDLE;
			bit_cnt_q <= 4'h0;
			sh_q <= 8'h00;
			byte_idx_q <= 3'h0;
			order_q <= 1'b0;
			rw_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else if (start_ev) begin
			st_q <= TSC_ST_ADDR;
			bit_cnt_q <= 4'h0;
			oe_n_q <= 1'b1;
		end else if (stop_ev) begin
			st_q <= TSC_ST_IDLE;
			oe_n_q <= 1'b1;
		end else begin
			unique case (st_q)
				TSC_ST_IDLE: begin
				end
				TSC_ST_ADDR, TSC_ST_WR: begin
					if (scl_rise) begin
						sh_q <= {sh_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == `TSC_BYTE_BITS) begin
						bit_cnt_q <= 4'h0;
						if (st_q == TSC_ST_WR) begin
							order_q <= ord_eff;
							st_q <= TSC_ST_WACK;
							oe_n_q <= 1'b0;
						end else if (sh_q[7:1] == DEV_ADDR) begin
							rw_q <= sh_q[0];
							st_q <= TSC_ST_AACK;
							oe_n_q <= 1'b0;
						end else begin
							st_q <= TSC_ST_IDLE;
						end
					end
				end
				TSC_ST_AACK: begin
					if (scl_fall) begin
						byte_idx_q <= 3'h0;
						if (rw_q) begin
							st_q <= TSC_ST_RD;
							sh_q <= stat_s2_q;
							oe_n_q <= stat_s2_q[7];
							bit_cnt_q <= 4'h1;
						end else begin
							st_q <= TSC_ST_WR;
							oe_n_q <= 1'b1;
						end
					end
				end
				TSC_ST_WACK: begin
					if (scl_fall) begin
						st_q <= TSC_ST_WR;
						oe_n_q <= 1'b1;
						// extra bytes beyond four are acknowledged and ignored
						if (byte_idx_q != `TSC_MAX_BYTES) begin
							byte_idx_q <= byte_idx_q + 3'h1;
						end
					end
				end
				TSC_ST_RD: begin
					if (scl_fall) begin
						if (bit_cnt_q == `TSC_BYTE_BITS) begin
							st_q <= TSC_ST_RACK;
							oe_n_q <= 1'b1;
						end else begin
							sh_q <= {sh_q[6:0], 1'b0};
							oe_n_q <= sh_q[6];
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
					end
				end
				TSC_ST_RACK: begin
					if (scl_rise && sda_s) begin
						st_q <= TSC_ST_IDLE;
					end else if (scl_fall) begin
						st_q <= TSC_ST_RD;
						sh_q <= stat_s2_q;
						oe_n_q <= stat_s2_q[7];
						bit_cnt_q <= 4'h1;
					end
				end
				default: begin
					st_q <= TSC_ST_IDLE;
					oe_n_q <= 1'b1;
				end
			endcase
		end
	end

	// open-drain pin only ever pulls low
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sda_out_q <= 1'b0;
		end else begin
			sda_out_q <= 1'b0;
		end
	end

	// ************************************************************
	// three-wire link crossing
	// ************************************************************
	tsc_link_rx #(
		.W(`TSC_TW_WIDTH),
		.CW(`TSC_CNT_WIDTH)
	) u_link (
		.link_clk(TW_CLK),
		.rst_n(RST_N),
		.tw_en(TW_EN),
		.tw_data(TW_DATA),
		.word_q(link_word),
		.cnt_gray_q(link_gray)
	);

	logic [`TSC_CNT_WIDTH-1:0] start_cnt_q, tw_len;
	logic en_fall, tw_commit, len_ok;
	assign en_fall = en_prev_q & ~en_sync_q[1];
	assign tw_len = gray2bin(gray_s2_q) - start_cnt_q;
	assign len_ok = (tw_len == `TSC_LEN_SHORT) | (tw_len == `TSC_LEN_MID) | (tw_len == `TSC_LEN_LONG);
	assign tw_commit = en_fall & len_ok;

	// count at frame start; the link clock is still idle at enable rise
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			start_cnt_q <= '0;
		end else if (en_sync_q[1] & ~en_prev_q) begin
			start_cnt_q <= gray2bin(gray_s2_q);
		end
	end

	// ************************************************************
	// synthesizer settings
	// ************************************************************
	tsc_ports_t ports_q;
	tsc_ctrl_t ctrl_q;
	tsc_ref_t ref_q;
	logic [14:0] div_q;
	logic [6:0] div_hi_q;
	tsc_ctrl_t tw_ctrl;
	assign tw_ctrl = tsc_ctrl_t'(word_s2_q[6:0]);

	// two-wire bytes apply as they arrive; a three-wire frame overrides after
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ports_q <= tsc_ports_t'(`TSC_PORTS_RST);
			ctrl_q <= tsc_ctrl_t'(`TSC_CTRL_RST);
			ref_q <= TSC_REF_64;
			div_q <= `TSC_DIV_RST;
			div_hi_q <= 7'h00;
		end else begin
			if (wr_done) begin
				unique case (role)
					TSC_ROLE_DIV_HI: div_hi_q <= sh_q[6:0];
					TSC_ROLE_DIV_LO: div_q <= {div_hi_q, sh_q};
					TSC_ROLE_CTRL: begin
						ctrl_q <= tsc_ctrl_t'(sh_q[6:0]);
						ref_q <= ref_sel(sh_q[2], sh_q[1]);
					end
					TSC_ROLE_BAND: ports_q <= band_of(sh_q);
					TSC_ROLE_NONE: begin
					end
				endcase
			end
			if (tw_commit) begin
				if (tw_len == `TSC_LEN_LONG) begin
					ports_q <= tsc_ports_t'(word_s2_q[26:23]);
					div_q <= word_s2_q[22:8];
					ctrl_q <= tw_ctrl;
					ref_q <= ref_sel(tw_ctrl.ref_ratio_select_a, tw_ctrl.ref_ratio_select_b);
				end else if (tw_len == `TSC_LEN_MID) begin
					ports_q <= tsc_ports_t'(word_s2_q[18:15]);
					div_q <= word_s2_q[14:0];
					if (ctrl_q.ref_ratio_select_b) begin
						ref_q <= TSC_REF_128;
					end
				end else begin
					ports_q <= tsc_ports_t'(word_s2_q[17:14]);
					div_q <= {1'b0, word_s2_q[13:0]};
					if (ctrl_q.ref_ratio_select_b) begin
						ref_q <= TSC_REF_64;
					end
				end
			end
		end
	end

	assign SDA_OUT = sda_out_q;
	assign SDA_OE_N = oe_n_q;
	assign PORTS = ports_q;
	assign DIVIDER_RATIO = div_q;
	assign CTRL = ctrl_q;
	assign REF_RATIO = ref_q;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	sequence s_byte0(logic b7);
		wr_done && !tw_commit && byte_idx_q == 3'h0 && sh_q[7] == b7;
	endsequence
	sequence s_ack_then_fall;
		st_q == TSC_ST_RACK && scl_fall && !start_ev && !stop_ev;
	endsequence

	chk_div_first_order: assert property (s_byte0(1'b0) |=> $stable(ctrl_q) && div_hi_q == $past(sh_q[6:0]))
		else $error("divider-first byte handled wrongly");
	chk_ctrl_first_order: assert property (s_byte0(1'b1) |=> ctrl_q == tsc_ctrl_t'($past(sh_q[6:0])) && $stable(div_q))
		else $error("control-first byte not applied");
	chk_div_pair_only: assert property (wr_done && !tw_commit && role == TSC_ROLE_DIV_LO |=> div_q == {$past(div_hi_q), $past(sh_q)} && $stable(ctrl_q) && $stable(ports_q))
		else $error("divider pair update wrong");
	chk_band_keeps_div: assert property (wr_done && !tw_commit && role == TSC_ROLE_BAND |=> $stable(div_q) && ports_q == band_of($past(sh_q)))
		else $error("band byte disturbed divider");
	chk_ctrl_alone: assert property (wr_done && !tw_commit && role == TSC_ROLE_CTRL |=> ref_q == ref_sel($past(sh_q[2]), $past(sh_q[1])) && $stable(ports_q))
		else $error("control byte not applied alone");
	chk_read_drive: assert property (st_q == TSC_ST_RD |-> oe_n_q == sh_q[7])
		else $error("read bit driven wrongly");
	chk_read_repeat: assert property (s_ack_then_fall |=> st_q == TSC_ST_RD && sh_q == $past(stat_s2_q) && bit_cnt_q == 4'h1)
		else $error("status not resent after acknowledge");
	chk_addr_dir: assert property (st_q == TSC_ST_AACK && scl_fall && !start_ev && !stop_ev |=> st_q == ($past(rw_q) ? TSC_ST_RD : TSC_ST_WR))
		else $error("direction bit ignored");
	chk_frame_len: assert property (en_fall && !len_ok && !wr_done |=> $stable(div_q) && $stable(ports_q) && $stable(ctrl_q))
		else $error("bad frame length took effect");
	chk_ref_short: assert property (tw_commit && tw_len == `TSC_LEN_SHORT && ctrl_q.ref_ratio_select_b |=> ref_q == TSC_REF_64)
		else $error("short frame ratio not 64");
	chk_ref_kept: assert property (tw_commit && tw_len != `TSC_LEN_LONG && !ctrl_q.ref_ratio_select_b |=> ref_q == TSC_REF_80)
		else $error("ratio 80 not kept");
	chk_ctrl_persist: assert property (tw_commit && tw_len != `TSC_LEN_LONG |=> $stable(ctrl_q))
		else $error("short frame changed control");

endmodule
`default_nettype wire

// ### bench/tsc_host_model.sv
// Purpose: host controller model driving the two-wire and three-wire links
// Assumes: two-wire quarter bit of Q system clocks; link clock only within frames
// Notes: released data lines idle high through the pull-up
`timescale 1ns/10ps
`default_nettype none
module tsc_host_model #(
	parameter int Q = 10
) (
	input wire logic clk, // paces the two-wire bus
	input wire logic sda_wire, // resolved data wire
	output logic scl, // two-wire clock
	output logic sda, // host data drive, 1 = released
	output logic tw_clk, // three-wire clock, 48 ns
	output logic tw_en, // three-wire enable
	output logic tw_data // three-wire data
);
	// ************************************************************
	// idle levels
	// ************************************************************
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		tw_clk = 1'b0;
		tw_en = 1'b0;
		tw_data = 1'b0;
	end

	// ************************************************************
	// two-wire bit, start, stop and byte
	// ************************************************************
	task automatic qw();
		repeat (Q) @(posedge clk);
	endtask

	// data held stable over the whole clock high phase
	task automatic bit_io(input logic b, output logic r);
		sda <= b;
		qw();
		scl <= 1'b1;
		qw();
		r = sda_wire;
		qw();
		scl <= 1'b0;
		qw();
	endtask

	// also serves as repeated start since it begins from clock low
	task automatic start();
		sda <= 1'b1;
		qw();
		scl <= 1'b1;
		qw();
		sda <= 1'b0;
		qw();
		scl <= 1'b0;
		qw();
	endtask

	task automatic stop();
		sda <= 1'b0;
		qw();
		scl <= 1'b1;
		qw();
		sda <= 1'b1;
		qw();
	endtask

	// last bit: 0 acks, 1 withholds acknowledge
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
		output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(last, a);
	endtask

	// ************************************************************
	// three-wire frame
	// ************************************************************
	// msb first, clock quiet around enable edges
	task automatic tw_frame(input int n, input logic [26:0] v);
		#3 tw_en <= 1'b1;
		#60;
		for (int i = n - 1; i >= 0; i--) begin
			tw_data <= v[i];
			#24 tw_clk <= 1'b1;
			#24 tw_clk <= 1'b0;
		end
		#60 tw_en <= 1'b0;
		tw_data <= ~v[0];
	endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Purpose: self-checking bench of the serial control front end
// Assumes: host model paces both links; outputs settle within ten clocks
// Notes: the data wire is resolved here from the host and the pull-down enable
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import tsc_pkg::*;
	logic sys_clk;
	logic rst_n;
	logic [7:0] status_in;
	logic scl, sda, sda_out, sda_oe_n, tw_clk, tw_en, tw_data;
	wire logic sda_wire;
	tsc_ports_t ports;
	logic [14:0] divider;
	tsc_ctrl_t ctrl;
	tsc_ref_t ref_ratio;
	logic [7:0] r;
	logic a;
	int mismatches;
	int n_tests;

	// pull-up wins unless either party pulls low
	assign sda_wire = sda & sda_oe_n;

	tsc_top tsc_top_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_wire),
		.SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .STATUS_IN(status_in), .TW_CLK(tw_clk),
		.TW_EN(tw_en), .TW_DATA(tw_data), .PORTS(ports), .DIVIDER_RATIO(divider),
		.CTRL(ctrl), .REF_RATIO(ref_ratio));
	tsc_host_model host_inst (.clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda(sda),
		.tw_clk(tw_clk), .tw_en(tw_en), .tw_data(tw_data));

	// ************************************************************
	// compare and report
	// ************************************************************
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_out(input logic [3:0] p, input logic [14:0] d, input logic [6:0] c,
		input tsc_ref_t rr);
		chk("ports", {12'h000, p}, {12'h000, ports});
		chk("divider", {1'b0, d}, {1'b0, divider});
		chk("control", {9'h000, c}, {9'h000, ctrl});
		chk("ref ratio", {14'h0000, rr}, {14'h0000, ref_ratio});
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ************************************************************
	// access tasks
	// ************************************************************
	// one write transfer of n bytes taken from the top of d
	task automatic wr(input logic [7:0] adr, input int n, input logic [31:0] d,
		input logic ackx);
		host_inst.start();
		host_inst.xfer(adr, 1'b1, r, a);
		chk("address ack", {15'h0000, ackx}, {15'h0000, a});
		for (int i = 0; i < n; i++) begin
			// bytes past the fourth are sent as all ones
			host_inst.xfer((i < 4) ? d[31-8*i -: 8] : 8'hff, 1'b1, r, a);
			chk("data ack", {15'h0000, ackx}, {15'h0000, a});
		end
		host_inst.stop();
		repeat (10) @(posedge sys_clk);
	endtask

	task automatic frame(input int n, input logic [26:0] v);
		@(posedge sys_clk);
		host_inst.tw_frame(n, v);
		// frames stay at least 10 us apart
		repeat (1000) @(posedge sys_clk);
	endtask

	// ************************************************************
	// clock and watchdog
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// a hang counts as a mismatch
	initial begin
		#500000;
		mismatches++;
		complete_run();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		mismatches = 0;
		n_tests = 0;
		rst_n = 1'b0;
		status_in = 8'ha5;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk_out(4'h0, 15'h0000, 7'h42, TSC_REF_64);
		chk("release", 16'h0001, {15'h0000, sda_oe_n});
		chk("drive value", 16'h0000, {15'h0000, sda_out});
		// divider first, then control and band bytes
		wr(8'hc2, 4, 32'h0640ce09, 1'b0);
		chk_out(4'b0101, 15'h0640, 7'h4e, TSC_REF_128);
		wr(8'hc2, 4, 32'h82041234, 1'b0);
		chk_out(4'b1000, 15'h1234, 7'h02, TSC_REF_64);
		// a fifth byte is acknowledged and changes nothing
		wr(8'hc2, 5, 32'h82041234, 1'b0);
		chk_out(4'b1000, 15'h1234, 7'h02, TSC_REF_64);
		wr(8'hc2, 2, 32'h05000000, 1'b0);
		chk_out(4'b1000, 15'h0500, 7'h02, TSC_REF_64);
		wr(8'hc2, 2, 32'hc6020000, 1'b0);
		chk_out(4'b0010, 15'h0500, 7'h46, TSC_REF_128);
		wr(8'hc2, 1, 32'h80000000, 1'b0);
		chk_out(4'b0010, 15'h0500, 7'h00, TSC_REF_80);
		// foreign address is neither acknowledged nor applied
		wr(8'hc4, 2, 32'h7fff0000, 1'b1);
		chk_out(4'b0010, 15'h0500, 7'h00, TSC_REF_80);
		// read: first byte acknowledged, repeat carries the fresh status
		host_inst.start();
		host_inst.xfer(8'hc3, 1'b1, r, a);
		chk("read address ack", 16'h0000, {15'h0000, a});
		for (int i = 7; i >= 0; i--) begin
			host_inst.bit_io(1'b1, r[i]);
		end
		chk("status byte", 16'h00a5, {8'h00, r});
		status_in <= 8'h3c;
		host_inst.bit_io(1'b0, a);
		host_inst.xfer(8'hff, 1'b1, r, a);
		chk("repeated status", 16'h003c, {8'h00, r});
		host_inst.stop();
		repeat (10) @(posedge sys_clk);
		chk("released after read", 16'h0001, {15'h0000, sda_oe_n});
		// three-wire frames
		frame(18, {4'b1000, 14'h3900});
		chk_out(4'b1000, 15'h3900, 7'h00, TSC_REF_80);
		frame(27, {4'b1000, 15'h1234, 8'h82});
		chk_out(4'b1000, 15'h1234, 7'h02, TSC_REF_64);
		frame(19, {4'b0100, 15'h5140});
		chk_out(4'b0100, 15'h5140, 7'h02, TSC_REF_128);
		frame(18, {4'b0001, 14'h2abc});
		chk_out(4'b0001, 15'h2abc, 7'h02, TSC_REF_64);
		// wrong lengths leave everything as it was
		frame(20, 27'h7ffffff);
		frame(26, 27'h7ffffff);
		chk_out(4'b0001, 15'h2abc, 7'h02, TSC_REF_64);
		frame(27, {4'b1000, 15'h3a98, 8'h88});
		chk_out(4'b1000, 15'h3a98, 7'h08, TSC_REF_80);
		frame(19, {4'b1000, 15'h2ee0});
		chk_out(4'b1000, 15'h2ee0, 7'h08, TSC_REF_80);
		// a fresh reset brings select B back to one
		rst_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk_out(4'h0, 15'h0000, 7'h42, TSC_REF_64);
		frame(19, {4'b0010, 15'h1f40});
		chk_out(4'b0010, 15'h1f40, 7'h42, TSC_REF_128);
		complete_run();
	end
endmodule
`default_nettype wire
